// *** inc/crc_check_defines.svh ***
`ifndef CRC_CHECK_DEFINES_SVH
`define CRC_CHECK_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_SIGNATURE  8'h08
`define OFS_EXPECTED   8'h0C
`define OFS_INT_STAT   8'h10
`define OFS_INT_CLR    8'h14
`define OFS_INT_EN     8'h18
// Control fields
`define CTRL_USER_MODE 0
`define CTRL_PIN_EN    1
// Interrupt status fields
`define IRQ_FRAME_ERR  0
`define IRQ_SIG_ERR    1
`define IRQ_PASS_DONE  2
// Reset values and polynomials
`define CTRL_RST       32'h0000_0000
`define CRC16_POLY     16'h8005
`define CRC32_POLY     32'h04C1_1DB7
`define CRC16_INIT     16'hFFFF
`define CRC32_INIT     32'hFFFF_FFFF

`endif

// *** inc/crc_check_pkg.sv ***
package crc_check_pkg;
    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // Frame checker sequence
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_DATA = 2'b01,
        FR_CHK  = 2'b11
    } frame_state_e;
endpackage

// *** logic/config_memory_crc_checker.sv ***
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`include "crc_check_defines.svh"

module config_memory_crc_checker #(
    parameter int FRAME_WORDS = 16,
    parameter int MEM_WORDS = 64,
    parameter int ADDR_W = 16
) (
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // Wishbone slave
    input wire crc_check_pkg::wb_req_s WB_REQ,
    output logic WB_ACK,
    output logic [31:0] WB_DAT_O,
    // Configuration frame stream
    input wire logic FRM_VALID,
    input wire logic [15:0] FRM_DATA,
    input wire logic FRM_LAST,
    // Configuration memory scan port
    output logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic [15:0] MEM_DATA,
    input wire logic [31:0] MEM_EXPECTED,
    // Status pins and interrupt
    output logic CONFIG_FAULT_LINE_N,
    output logic CRC_ERR_PIN,
    output logic IRQ
);
    import crc_check_pkg::*;

    // Registers, scan pointer and per-cycle events
    logic [31:0] ctrl_r;
    logic [31:0] crc_signature_r;
    logic [31:0] crc_expected_value_r;
    logic [31:0] crc32_r;
    logic [15:0] crc16_r;
    logic [2:0] int_stat_r;
    logic [2:0] int_en_r;
    logic [ADDR_W-1:0] scan_addr_r;
    logic scan_valid_r;
    logic [$clog2(FRAME_WORDS+1)-1:0] word_cnt_r;
    logic fault_r;
    frame_state_e fr_state_r;
    logic frame_err_ev;
    logic pass_done_ev;
    logic sig_err_ev;
    logic user_mode;
    logic wb_hit;

    // Serial CRC step over one 16-bit word, MSB first
    function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ (((r[15] ^ d[i]) == 1'b1) ? `CRC16_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Same walk on 32 bits; no reflection and no final XOR on either
    function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [15:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ (((r[31] ^ d[i]) == 1'b1) ? `CRC32_POLY : 32'h0000_0000);
        end
        return r;
    endfunction

    // Mode bit and a fresh request; ack low keeps one transfer from counting twice
    assign user_mode = ctrl_r[`CTRL_USER_MODE];
    assign wb_hit = WB_REQ.cyc && WB_REQ.stb && !WB_ACK;

    // Per-frame checker: data words, then the embedded check word
    // FRM_LAST is not used; the word counter alone closes a frame
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            fr_state_r <= FR_IDLE;
            crc16_r <= `CRC16_INIT;
            word_cnt_r <= '0;
        end else if (CE) begin
            unique case (fr_state_r)
                FR_IDLE: begin
                    crc16_r <= `CRC16_INIT;
                    word_cnt_r <= '0;
                    if (FRM_VALID && !user_mode) begin
                        crc16_r <= crc16_step(`CRC16_INIT, FRM_DATA);
                        word_cnt_r <= ($bits(word_cnt_r))'(1);
                        fr_state_r <= (FRAME_WORDS == 1) ? FR_CHK : FR_DATA;
                    end
                end
                FR_DATA: begin
                    if (FRM_VALID) begin
                        crc16_r <= crc16_step(crc16_r, FRM_DATA);
                        word_cnt_r <= word_cnt_r + 1'b1;
                        // Frame length fixed per device, not per frame
                        if (word_cnt_r == ($bits(word_cnt_r))'(FRAME_WORDS - 1)) begin
                            fr_state_r <= FR_CHK;
                        end
                    end
                end
                FR_CHK: begin
                    // Next word is the precomputed 16-bit value
                    if (FRM_VALID) begin
                        fr_state_r <= FR_IDLE;
                    end
                end
                default: fr_state_r <= FR_IDLE;
            endcase
        end
    end

    // Check word against the running value, a one-cycle pulse
    assign frame_err_ev = CE && fr_state_r == FR_CHK && FRM_VALID && FRM_DATA != crc16_r;

    // Fault line stays low until the next reset; reconfiguration restarts
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            fault_r <= 1'b0;
        end else if (CE && frame_err_ev) begin
            fault_r <= 1'b1;
        end
    end

    // User-mode scan of the whole memory, restarting after each pass
    // The memory must stall with CE as well, or the read pipeline slips a word
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            scan_addr_r <= '0;
            scan_valid_r <= 1'b0;
            crc32_r <= `CRC32_INIT;
        end else if (CE) begin
            if (!user_mode) begin
                scan_addr_r <= '0;
                scan_valid_r <= 1'b0;
                crc32_r <= `CRC32_INIT;
            end else begin
                // Memory read has one cycle of latency
                scan_valid_r <= 1'b1;
                scan_addr_r <= (scan_addr_r == ADDR_W'(MEM_WORDS - 1)) ? '0 : scan_addr_r + 1'b1;
                if (scan_valid_r) begin
                    crc32_r <= pass_done_ev ? `CRC32_INIT : crc32_step(crc32_r, MEM_DATA);
                end
            end
        end
    end

    // Address back at zero with valid data: last word of the pass is on MEM_DATA
    assign pass_done_ev = CE && user_mode && scan_valid_r && scan_addr_r == '0;

    // Signature is computed XOR expected; zero means memory intact
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            crc_signature_r <= '0;
            crc_expected_value_r <= '0;
        end else if (CE && pass_done_ev) begin
            crc_expected_value_r <= MEM_EXPECTED;
            crc_signature_r <= crc32_step(crc32_r, MEM_DATA) ^ MEM_EXPECTED;
        end
    end

    // Non-zero signature at the end of a pass
    assign sig_err_ev = pass_done_ev && ((crc32_step(crc32_r, MEM_DATA) ^ MEM_EXPECTED) != '0);

    // Pins come straight from flops
    // Pin enable gates only the pin; the signature register updates either way
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            CONFIG_FAULT_LINE_N <= 1'b1;
            CRC_ERR_PIN <= 1'b0;
            IRQ <= 1'b0;
        end else if (CE) begin
            CONFIG_FAULT_LINE_N <= !(fault_r || frame_err_ev);
            CRC_ERR_PIN <= ctrl_r[`CTRL_PIN_EN] && (crc_signature_r != '0);
            IRQ <= |(int_stat_r & int_en_r);
        end
    end

    // Sticky events; a set in the clear cycle wins
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            int_stat_r <= '0;
        end else if (CE) begin
            int_stat_r <= (int_stat_r & ~((wb_hit && WB_REQ.we && WB_REQ.adr == `OFS_INT_CLR) ?
                          WB_REQ.dat[2:0] : 3'b000)) | {pass_done_ev, sig_err_ev, frame_err_ev};
        end
    end

    // Wishbone writes, single-cycle ack
    // Writes act at the taking edge, the same edge that raises ack
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= `CTRL_RST;
            int_en_r <= '0;
            WB_ACK <= 1'b0;
        end else if (CE) begin
            WB_ACK <= wb_hit;
            if (wb_hit && WB_REQ.we && WB_REQ.sel[0]) begin
                if (WB_REQ.adr == `OFS_CTRL) begin
                    ctrl_r <= {30'h0000_0000, WB_REQ.dat[1:0]};
                end
                if (WB_REQ.adr == `OFS_INT_EN) begin
                    int_en_r <= WB_REQ.dat[2:0];
                end
            end
        end
    end

    // Read data, unmapped reads zero
    // Status: bit0 signature non-zero, bit1 fault, bit2 frame checker idle
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            WB_DAT_O <= '0;
        end else if (CE && wb_hit) begin
            unique case (WB_REQ.adr)
                `OFS_CTRL: WB_DAT_O <= ctrl_r;
                `OFS_STATUS: WB_DAT_O <= {29'h0000_0000, fr_state_r == FR_IDLE, fault_r, crc_signature_r != '0};
                `OFS_SIGNATURE: WB_DAT_O <= crc_signature_r;
                `OFS_EXPECTED: WB_DAT_O <= crc_expected_value_r;
                `OFS_INT_STAT: WB_DAT_O <= {29'h0000_0000, int_stat_r};
                `OFS_INT_EN: WB_DAT_O <= {29'h0000_0000, int_en_r};
                default: WB_DAT_O <= '0;
            endcase
        end
    end

    // Scan address leaves straight from its flop
    assign MEM_ADDR = scan_addr_r;

    // Checks
    a_fault_on_mismatch: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        frame_err_ev |=> !CONFIG_FAULT_LINE_N) else $error("fault line not low after mismatch");
    a_err_pin_follows: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && ctrl_r[1] && crc_signature_r != '0 |=> CRC_ERR_PIN) else $error("error pin not high");
    a_pin_gated_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && !ctrl_r[1] |=> !CRC_ERR_PIN) else $error("error pin high while disabled");
    a_sig_on_pass: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !pass_done_ev && CE |=> $stable(crc_signature_r)) else $error("signature changed mid pass");
    a_scan_restart: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && user_mode && scan_addr_r == ADDR_W'(MEM_WORDS - 1) |=> scan_addr_r == '0)
        else $error("scan did not wrap");
    a_expected_load: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        pass_done_ev |=> crc_expected_value_r == $past(MEM_EXPECTED)) else $error("expected not loaded");
    a_frame_length: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && fr_state_r == FR_DATA && FRM_VALID && word_cnt_r == FRAME_WORDS - 1 |=> fr_state_r == FR_CHK)
        else $error("frame length wrong");
    a_check_word: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && fr_state_r == FR_CHK && FRM_VALID |=> fr_state_r == FR_IDLE) else $error("check word not taken");
    a_fault_sticks: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !CONFIG_FAULT_LINE_N |=> !CONFIG_FAULT_LINE_N) else $error("fault line released");

    // Scan, signature and frame checks
    a_user_refuse: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && user_mode && fr_state_r == FR_IDLE |=> fr_state_r == FR_IDLE)
        else $error("frame taken in user mode");
    a_fault_needs_err: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CONFIG_FAULT_LINE_N && !frame_err_ev |=> CONFIG_FAULT_LINE_N)
        else $error("fault line low without mismatch");
    a_check_compare: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && fr_state_r == FR_CHK && FRM_VALID && FRM_DATA == crc16_r && !fault_r |=> CONFIG_FAULT_LINE_N)
        else $error("fault line low on matching check word");
    a_frame_count: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        fr_state_r == FR_DATA |-> word_cnt_r != '0 && word_cnt_r < FRAME_WORDS)
        else $error("word count out of range");
    a_sig_zero_pin: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && crc_signature_r == '0 |=> !CRC_ERR_PIN)
        else $error("error pin high with zero signature");
    a_sig_err_set: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        sig_err_ev |=> crc_signature_r != '0)
        else $error("signature zero after failing pass");
    a_crc_restart: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        pass_done_ev |=> crc32_r == `CRC32_INIT)
        else $error("calculation not restarted");
    a_pass_flag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        pass_done_ev |=> int_stat_r[`IRQ_PASS_DONE])
        else $error("pass event not recorded");
    a_scan_idle: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && !user_mode |=> scan_addr_r == '0 && !scan_valid_r)
        else $error("scan running outside user mode");
    a_scan_valid: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        CE && user_mode |=> scan_valid_r)
        else $error("scan not running in user mode");
    a_exp_stable: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !pass_done_ev |=> $stable(crc_expected_value_r))
        else $error("expected value changed mid pass");

    // Scenarios worth seeing
    c_frame_err: cover property (@(posedge CLK_SYS) frame_err_ev);
    c_pass_ok: cover property (@(posedge CLK_SYS) pass_done_ev && !sig_err_ev);
    c_sig_err: cover property (@(posedge CLK_SYS) sig_err_ev);
    c_irq: cover property (@(posedge CLK_SYS) IRQ);
    c_err_pin: cover property (@(posedge CLK_SYS) CRC_ERR_PIN);
endmodule

// *** sim/cfg_mem_model.sv ***
`timescale 1ns/10ps

// Configuration memory seen by the scan port
module cfg_mem_model #(
    parameter int MEM_WORDS = 64,
    parameter int ADDR_W = 16
) (
    // Clock and enable
    input wire logic clk,
    input wire logic en,
    // Scan port
    input wire logic [ADDR_W-1:0] addr,
    output logic [15:0] data
);
    logic [15:0] mem [MEM_WORDS];

    // Registered read, one cycle behind the address; holds while the block is frozen
    always_ff @(posedge clk) begin
        if (en) begin
            data <= mem[addr];
        end
    end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`include "crc_check_defines.svh"

module tb_top;
    import crc_check_pkg::*;
    localparam int FW = 16;
    localparam int MW = 64;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    wb_req_s req = '0;
    logic ack, fault_n, err_pin, irq;
    logic ce = 1'b1;
    logic frm_valid = 1'b0;
    logic [15:0] frm_data = 16'h0000;
    logic [15:0] mem_data, mem_addr;
    logic [31:0] dat_o, q, crc, r;
    logic [31:0] mem_exp = 32'h0000_0000;
    logic [15:0] fq[$];
    int n_fail = 0;
    int n_checks = 0;

    // Clock, 8 ns period
    always #4 clk_sys = ~clk_sys;

    config_memory_crc_checker #(.FRAME_WORDS(FW), .MEM_WORDS(MW), .ADDR_W(16)) u_config_memory_crc_checker (
        .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .WB_REQ(req), .WB_ACK(ack), .WB_DAT_O(dat_o),
        .FRM_VALID(frm_valid), .FRM_DATA(frm_data), .FRM_LAST(1'b0), .MEM_ADDR(mem_addr),
        .MEM_DATA(mem_data), .MEM_EXPECTED(mem_exp), .CONFIG_FAULT_LINE_N(fault_n),
        .CRC_ERR_PIN(err_pin), .IRQ(irq));
    cfg_mem_model #(.MEM_WORDS(MW), .ADDR_W(16)) u_cfg_mem_model (.clk(clk_sys), .addr(mem_addr),
        .en(ce), .data(mem_data));

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // Classic single cycle; holds the request until ack is sampled
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        int i;
        @(posedge clk_sys);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            chk("ack timeout", 1, 0);
            test_done();
        end
        rd = dat_o;
        req <= '0;
    endtask

    // Wait for a fresh pass-done event, bounded
    task poll_done;
        int i;
        wb(1'b1, `OFS_INT_CLR, 32'h0000_0004, q);
        for (i = 0; i < 60; i++) begin
            wb(1'b0, `OFS_INT_STAT, 0, q);
            if (q[2] === 1'b1) break;
        end
        if (i == 60) begin
            chk("pass timeout", 1, 0);
            test_done();
        end
    endtask

    function automatic logic [15:0] crc16_q();
        logic [15:0] c;
        c = `CRC16_INIT;
        foreach (fq[k])
            for (int b = 15; b >= 0; b--)
                c = (c[15] ^ fq[k][b]) ? ((c << 1) ^ `CRC16_POLY) : (c << 1);
        return c;
    endfunction

    function automatic logic [31:0] crc32_mem();
        logic [31:0] c;
        c = `CRC32_INIT;
        for (int k = 0; k < MW; k++)
            for (int b = 15; b >= 0; b--)
                c = (c[31] ^ u_cfg_mem_model.mem[k][b]) ? ((c << 1) ^ `CRC32_POLY) : (c << 1);
        return c;
    endfunction

    // Random frame, then its check word, optionally corrupted
    task send_frame(input logic bad);
        fq.delete();
        repeat (FW) fq.push_back(16'($urandom));
        foreach (fq[k]) begin
            @(posedge clk_sys);
            frm_valid <= 1'b1;
            frm_data <= fq[k];
        end
        @(posedge clk_sys);
        frm_data <= crc16_q() ^ {15'h0000, bad};
        @(posedge clk_sys);
        frm_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("fault_n", {31'h0, ~bad}, {31'h0, fault_n});
    endtask

    initial begin
        void'($urandom(32'h2a9f));
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        wb(1'b0, `OFS_CTRL, 0, q);
        chk("ctrl", `CTRL_RST, q);
        wb(1'b0, 8'h1C, 0, q);
        chk("unmapped", 0, q);
        wb(1'b0, `OFS_INT_STAT, 0, q);
        chk("int_stat", 0, q);
        $display("test registers done");
        // Frame checks with the frame-error interrupt enabled
        wb(1'b1, `OFS_INT_EN, 32'h0000_0001, q);
        send_frame(1'b0);
        chk("irq", 0, irq);
        send_frame(1'b1);
        wb(1'b0, `OFS_INT_STAT, 0, q);
        chk("int_stat", 1, q);
        chk("irq", 1, irq);
        wb(1'b1, `OFS_INT_CLR, 32'h0000_0001, q);
        repeat (2) @(posedge clk_sys);
        chk("irq", 0, irq);
        chk("fault_n", 0, fault_n);
        $display("test frames done");
        // User-mode scan, matching expected value first
        for (int k = 0; k < MW; k++)
            u_cfg_mem_model.mem[k] = 16'($urandom);
        crc = crc32_mem();
        mem_exp <= crc;
        wb(1'b1, `OFS_CTRL, 32'h0000_0001, q);
        poll_done();
        wb(1'b0, `OFS_SIGNATURE, 0, q);
        chk("signature", 0, q);
        wb(1'b0, `OFS_EXPECTED, 0, q);
        chk("expected", crc, q);
        chk("err_pin", 0, err_pin);
        // Clock enable low freezes the scan; the memory stalls with it
        @(posedge clk_sys);
        ce <= 1'b0;
        @(posedge clk_sys);
        q = {16'h0000, mem_addr};
        repeat (4) @(posedge clk_sys);
        chk("frozen addr", q, {16'h0000, mem_addr});
        ce <= 1'b1;
        // Wrong expected value, pin disabled then enabled
        r = $urandom | 32'h0000_0001;
        mem_exp <= crc ^ r;
        poll_done();
        wb(1'b0, `OFS_SIGNATURE, 0, q);
        chk("signature", r, q);
        wb(1'b0, `OFS_INT_STAT, 0, q);
        chk("sig_err", 1, q[1]);
        wb(1'b0, `OFS_STATUS, 0, q);
        chk("status", 32'h0000_0007, q);
        wb(1'b0, `OFS_INT_EN, 0, q);
        chk("int_en", 32'h0000_0001, q);
        chk("err_pin", 0, err_pin);
        wb(1'b1, `OFS_CTRL, 32'h0000_0003, q);
        poll_done();
        repeat (2) @(posedge clk_sys);
        chk("err_pin", 1, err_pin);
        $display("test scan done");
        test_done();
    end
endmodule
